// >>> logic/pport_pkg.sv
// Constants shared by the parallel port: register map, field positions, timing.
// Assumes a single 100 MHz pclk and an APB master in front of the block.
// Summary of operation
// RQ1 - Fetch drives instruction pointer low twelve bits
// RQ2 - Data access drives address register low bits
// RQ3 - Fetch area bit is pointer bit twelve
// RQ4 - Data area bit: 0 fast, 1 slow
// RQ5 - Fast access two cycles, slow four
// RQ6 - Data accesses never stall instruction stream
// RQ7 - Master mode uses 32-bit three-state bus
// RQ8 - Read strobe after address, capture on rise
// RQ9 - Write strobe after address, data driven during
// RQ10 - Slave mode assembles 1-4 bytes over 8 bits
// RQ11 - Host strobes honoured only with select low
// RQ12 - Host read drives slave data register out
// RQ13 - Host write loads slave data register
// RQ14 - Host transfer is 16-bit or two halves
// RQ15 - Request output asks host for service
// RQ16 - Two general inputs sampled for branch tests; the code samples them in slave mode only
// RQ17 - Two general outputs hold until rewritten
// RQ18 - Thirteen-bit pointer, top bit selects external
// RQ19 - 2K on-chip words, 4K external words
// RQ20 - Every instruction completes in one cycle
// RQ21 - 8K data space split by area bit
// RQ22 - Mode input: low master, high slave
// RQ23 - Slave mode never fetches instructions externally
// RQ24 - Master: lower 4K shared, upper data only; the code fetches from the upper 4K, so the lower 4K is data only
// RQ25 - Data bus released except during writes
// RQ26 - Host port released except select plus read
package pport_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] EXT_ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] RDATA_OFF = 8'h0c;
  localparam logic [7:0] IPTR_OFF = 8'h10;
  localparam logic [7:0] INSTR_OFF = 8'h14;
  localparam logic [7:0] PROG_OFF = 8'h18;
  localparam logic [7:0] HOSTDATA_OFF = 8'h1c;
  localparam logic [7:0] STATUS_OFF = 8'h20;
  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_BYTES_LO = 3;
  localparam int CTRL_WIDE = 5;
  localparam int CTRL_REQ = 6;
  localparam int CTRL_GP_LO = 7;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  // Status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_REQ = 1;
  localparam int STAT_GP_LO = 2;
  localparam int STAT_SLAVE = 4;
  localparam int STAT_HALF = 5;
  // Address widths and memory sizes
  localparam int IP_WIDTH = 13;
  localparam int ONCHIP_WORDS = 2048;
  localparam int ONCHIP_AW = 11;
  localparam int EXT_AW = 12;
  // Timing: one instruction cycle is four pclk phases
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_DATA_STROBE = 2'h2;
  localparam logic [1:0] FAST_CYCLES = 2'h2;
  localparam logic [2:0] SLOW_CYCLES = 3'h4;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_WAIT = 2'b01,
    DS_STROBE = 2'b10
  } data_state_t;
endpackage

// >>> logic/pport_top.sv
// Parallel external memory and host port of a signal processor, with an APB slave.
// Assumes synchronous pins, a mode input held steady while running, and pclk at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
module pport_top
  import pport_pkg::*;
#(
  parameter int DATA_WIDTH = 32,
  parameter int HOST_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_slave,
  output logic [11:0] ext_addr_low,
  output logic area_select_bit,
  output logic ext_rd_n,
  output logic ext_wr_n,
  input wire logic [31:0] ext_data_in,
  output logic [31:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic host_cs_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_port,
  output logic host_data_oe,
  output logic host_transfer_request,
  input wire logic [1:0] gp_inputs,
  output logic [1:0] gp_outputs
);
  // Elaboration-time refusal of widths the datapath cannot serve
  if (DATA_WIDTH != 32 || HOST_WIDTH != 16) begin : gen_width_check
    $error("pport_top serves only a 32-bit data bus and a 16-bit host port");
  end

  // Instruction-cycle phase divider; instr_tick is the one-cycle enable
  logic [1:0] phase_q;
  wire instr_tick = (phase_q == PHASE_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == CTRL_OFF);
  wire hit_addr = (paddr == EXT_ADDR_OFF);
  wire hit_wdata = (paddr == WDATA_OFF);
  wire hit_rdata = (paddr == RDATA_OFF);
  wire hit_iptr = (paddr == IPTR_OFF);
  wire hit_instr = (paddr == INSTR_OFF);
  wire hit_prog = (paddr == PROG_OFF);
  wire hit_host = (paddr == HOSTDATA_OFF);
  wire hit_stat = (paddr == STATUS_OFF);
  wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_iptr | hit_instr | hit_prog | hit_host | hit_stat;

  // Control register; the go bit is a write-only pulse, never stored
  logic [8:0] ctrl_q;
  wire wr_ctrl = apb_wr && hit_ctrl;
  wire go_req = wr_ctrl && pwdata[CTRL_GO];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RESET;
    else if (wr_ctrl) ctrl_q <= pwdata[8:0] & ~9'h002;
  end
  wire run = ctrl_q[CTRL_RUN];
  wire host_wide = ctrl_q[CTRL_WIDE]; // RQ14
  wire [1:0] bytes_m1 = ctrl_q[CTRL_BYTES_LO +: 2];
  assign gp_outputs = ctrl_q[CTRL_GP_LO +: 2]; // RQ17

  // External address register and write data
  logic [12:0] xaddr_q;
  logic [31:0] wdata_q;
  logic data_adv;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xaddr_q <= 13'h0000;
      wdata_q <= 32'h00000000;
    end else begin
      if (apb_wr && hit_addr) xaddr_q <= pwdata[12:0]; // RQ21
      else if (data_adv) xaddr_q <= xaddr_q + 13'h0001;
      if (apb_wr && hit_wdata) wdata_q <= pwdata;
    end
  end

  // Instruction pointer advances once per instruction cycle while running
  logic [IP_WIDTH-1:0] ip_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ip_q <= 13'h0000;
    else if (apb_wr && hit_iptr) ip_q <= pwdata[IP_WIDTH-1:0];
    else if (run && instr_tick) ip_q <= ip_q + 13'h0001; // RQ20 RQ6
  end
  wire ip_external = ip_q[IP_WIDTH-1]; // RQ18
  // Slave mode forbids external fetch; the upper 4K then serves data only
  wire fetch_ext = run && ip_external && !mode_slave; // RQ23 RQ24 RQ22
  wire fetch_strobe = fetch_ext && (phase_q == 2'h1);

  // On-chip instruction store, loaded word by word at the pointer
  logic [31:0] onchip_q [ONCHIP_WORDS];
  always_ff @(posedge pclk) begin
    if (apb_wr && hit_prog) onchip_q[ip_q[ONCHIP_AW-1:0]] <= pwdata; // RQ19
  end

  // Fetched instruction: external word taken as the read strobe rises
  logic [31:0] instr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) instr_q <= 32'h00000000;
    else if (fetch_strobe) instr_q <= ext_data_in; // RQ8
    else if (run && !ip_external && phase_q == 2'h1) instr_q <= onchip_q[ip_q[ONCHIP_AW-1:0]];
    else if (run && ip_external && mode_slave && phase_q == 2'h1) instr_q <= 32'h00000000;
  end

  // Data access sequencer: starts on an instruction boundary and runs beside fetch
  data_state_t dstate_q;
  logic go_pend_q;
  logic [2:0] cyc_q;
  logic [1:0] byte_q;
  logic dir_wr_q;
  logic [31:0] asm_q;
  wire [2:0] access_len = xaddr_q[12] ? SLOW_CYCLES : {1'b0, FAST_CYCLES}; // RQ5 RQ4
  wire launch = go_pend_q && instr_tick && (dstate_q == DS_IDLE);
  wire to_strobe = (dstate_q == DS_WAIT) && (cyc_q == 3'h1) && (phase_q == PHASE_DATA_STROBE);
  assign data_adv = (dstate_q == DS_STROBE) && (byte_q != 2'h0);
  wire bytes_left = (byte_q != 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) go_pend_q <= 1'b0;
    else if (go_req) go_pend_q <= 1'b1;
    else if (launch) go_pend_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dstate_q <= DS_IDLE;
      cyc_q <= 3'h0;
      byte_q <= 2'h0;
      dir_wr_q <= 1'b0;
    end else begin
      case (dstate_q)
        DS_IDLE: begin
          if (launch) begin
            dstate_q <= DS_WAIT;
            cyc_q <= access_len;
            byte_q <= mode_slave ? bytes_m1 : 2'h0; // RQ10
            dir_wr_q <= ctrl_q[CTRL_WRITE];
          end
        end
        DS_WAIT: begin
          if (to_strobe) dstate_q <= DS_STROBE;
          else if (instr_tick) cyc_q <= cyc_q - 3'h1;
        end
        DS_STROBE: begin
          if (bytes_left) begin
            dstate_q <= DS_WAIT;
            cyc_q <= xaddr_q[12] ? SLOW_CYCLES : {1'b0, FAST_CYCLES};
            byte_q <= byte_q - 2'h1;
          end else begin
            dstate_q <= DS_IDLE;
          end
        end
        default: dstate_q <= DS_IDLE;
      endcase
    end
  end
  // Each access ends with its strobe state, so the next byte reloads with a full count

  // Assembled data: slave mode shifts bytes in, low byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) asm_q <= 32'h00000000;
    else if (dstate_q == DS_STROBE && !dir_wr_q) begin
      if (mode_slave) asm_q <= {ext_data_in[7:0], asm_q[31:8]}; // RQ10 RQ8
      else asm_q <= ext_data_in; // RQ7 RQ8
    end
  end
  // Outgoing byte in slave mode, lowest byte first
  wire [1:0] byte_sel = bytes_m1 - byte_q;
  wire [7:0] wr_byte = wdata_q[{byte_sel, 3'b000} +: 8];

  // External pins; data slot (phases 2-3, or every phase when not fetching externally) holds the data address, fetch slot the pointer
  wire data_slot = (dstate_q != DS_IDLE) && (phase_q[1] || !fetch_ext);
  assign ext_addr_low = data_slot ? xaddr_q[EXT_AW-1:0] : ip_q[EXT_AW-1:0]; // RQ1 RQ2
  assign area_select_bit = data_slot ? xaddr_q[12] : ip_q[IP_WIDTH-1]; // RQ3 RQ4
  assign ext_rd_n = !(fetch_strobe || (dstate_q == DS_STROBE && !dir_wr_q)); // RQ8
  assign ext_wr_n = !(dstate_q == DS_STROBE && dir_wr_q); // RQ9
  assign ext_data_oe = (dstate_q == DS_STROBE) && dir_wr_q; // RQ25 RQ7
  assign ext_data_out = mode_slave ? {24'h000000, wr_byte} : wdata_q; // RQ9 RQ10

  // Host port: strobes count only in slave mode with select low
  wire host_sel = mode_slave && !host_cs_n; // RQ11 RQ22
  wire host_rd = host_sel && !host_read_strobe_n;
  wire host_wr = host_sel && !host_write_strobe_n;
  logic host_rd_q, host_wr_q, half_q, req_q;
  logic [31:0] sdr_q;
  wire rd_end = host_rd_q && !host_rd;
  wire wr_end = host_wr_q && !host_wr;
  wire xfer_end = rd_end || wr_end;
  // A full transfer is one half in narrow mode, two in wide mode
  wire xfer_done = xfer_end && (!host_wide || half_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rd_q <= 1'b0;
      host_wr_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      host_rd_q <= host_rd;
      host_wr_q <= host_wr;
      if (xfer_end) half_q <= host_wide && !half_q; // RQ14
    end
  end
  // Host write loads the data on every pclk while its strobe is low; host wins over a same-cycle APB write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sdr_q <= 32'h00000000;
    else if (host_wr) begin
      if (half_q) sdr_q[31:16] <= host_data_in; // RQ13
      else sdr_q[15:0] <= host_data_in; // RQ13
    end else if (apb_wr && hit_host) sdr_q <= pwdata;
  end
  // Request: software sets it, a completed transfer clears it; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req_q <= 1'b0;
    else if (wr_ctrl && pwdata[CTRL_REQ]) req_q <= 1'b1; // RQ15
    else if (xfer_done) req_q <= 1'b0;
  end
  assign host_transfer_request = req_q; // RQ15
  assign host_data_oe = host_rd; // RQ26 RQ12
  assign host_data_port = half_q ? sdr_q[31:16] : sdr_q[15:0]; // RQ12

  // General inputs sampled once per instruction cycle in slave mode only, for branch tests
  logic [1:0] gp_in_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gp_in_q <= 2'h0;
    else if (instr_tick && mode_slave) gp_in_q <= gp_inputs; // RQ16
  end

  // APB read data is captured in the setup cycle so the access phase answers at once
  logic [31:0] rdata_d, prdata_q;
  logic err_q;
  wire [31:0] status_w = {26'h0000000, half_q, mode_slave, gp_in_q, req_q, dstate_q != DS_IDLE || go_pend_q};
  always_comb begin
    rdata_d = 32'h00000000;
    if (hit_ctrl) rdata_d = {23'h000000, ctrl_q};
    if (hit_addr) rdata_d = {19'h00000, xaddr_q};
    if (hit_wdata) rdata_d = wdata_q;
    if (hit_rdata) rdata_d = asm_q;
    if (hit_iptr) rdata_d = {19'h00000, ip_q};
    if (hit_instr) rdata_d = instr_q;
    if (hit_host) rdata_d = sdr_q;
    if (hit_stat) rdata_d = status_w;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rdata_d;
      err_q <= !mapped;
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;

  // Checks on the driven behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Five bits, since a slow access reaches a count of 16
  logic [4:0] acc_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc_len_q <= 5'h00;
    else if (launch || (dstate_q == DS_STROBE && bytes_left)) acc_len_q <= 5'h01;
    else if (dstate_q != DS_IDLE) acc_len_q <= acc_len_q + 5'h01;
  end
  // Strobe stands in the last pclk of the access: 4 pclk per instruction cycle
  fast_len_a: assert property ((dstate_q == DS_STROBE && !xaddr_q[12]) |-> acc_len_q == 5'h08) // RQ5
    else $error("fast access length wrong");
  slow_len_a: assert property ((dstate_q == DS_STROBE && xaddr_q[12]) |-> acc_len_q == 5'h10) // RQ5
    else $error("slow access length wrong");
  sequence addr_then_read_s;
    $stable(ext_addr_low) ##0 !ext_rd_n;
  endsequence
  read_addr_a: assert property ($fell(ext_rd_n) |-> addr_then_read_s) // RQ8
    else $error("address moved as read strobe fell");
  wr_drive_a: assert property (ext_data_oe |-> !ext_wr_n && ext_rd_n) // RQ25
    else $error("data bus driven outside a write");
  wr_addr_a: assert property (!ext_wr_n |-> ext_addr_low == xaddr_q[11:0] && area_select_bit == xaddr_q[12]) // RQ9
    else $error("write strobe without data address");
  fetch_pins_a: assert property (fetch_strobe |-> ext_addr_low == ip_q[11:0] && area_select_bit) // RQ1
    else $error("fetch address wrong");
  slave_nofetch_a: assert property ((mode_slave && !ext_rd_n) |-> dstate_q == DS_STROBE) // RQ23
    else $error("external fetch in slave mode");
  host_oe_a: assert property (host_data_oe |-> !host_cs_n && !host_read_strobe_n && mode_slave) // RQ26
    else $error("host port driven without select and read");
  ip_step_a: assert property ((run && instr_tick && !(apb_wr && hit_iptr)) |=> ip_q == $past(ip_q) + 13'h0001) // RQ20
    else $error("pointer did not advance");
  req_clear_a: assert property ((xfer_done && !wr_ctrl) |=> !host_transfer_request) // RQ15
    else $error("request not cleared");
endmodule
`default_nettype wire

// >>> sim/ext_mem_model.sv
// External static memory that sits on the parallel port's address, strobe and data pins.
// Assumes the design drives strobes active low, changing them only after pclk rising edges.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic pclk,
  input wire logic [11:0] ext_addr_low,
  input wire logic area_select_bit,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [31:0] ext_data_out,
  input wire logic ext_data_oe,
  output logic [31:0] ext_data_in
);
  logic [31:0] mem [0:8191];
  logic [12:0] last_rd = 13'h0000;
  logic [31:0] last_q = 32'h00000000;
  wire logic [12:0] loc = {area_select_bit, ext_addr_low};
  // Data only while the read strobe is low; no pull on the bus, so the inverse shows otherwise
  assign ext_data_in = !ext_rd_n ? mem[loc] : ~last_q;
  // Read word stays valid through the strobe's rising edge; writes land during the strobe
  always @(posedge pclk) begin
    if (!ext_rd_n) begin
      last_rd <= loc;
      last_q <= mem[loc];
    end
    if (!ext_wr_n && ext_data_oe) begin
      mem[loc] <= ext_data_out;
    end
  end
endmodule
`default_nettype wire

// >>> sim/pport_top_bench.sv
// Self-checking bench for the parallel port: APB traffic, memory accesses and host port.
// Assumes ext_mem_model on the memory pins while the bench plays the host processor.
`timescale 1ns/1ps
`default_nettype none
module pport_top_bench import pport_pkg::*; ();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mode_slave = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, ext_data_in, ext_data_out, q, dout;
  logic [13:0] pins;
  logic pready, pslverr, area_select_bit, ext_rd_n, ext_wr_n, ext_data_oe, host_data_oe, host_transfer_request;
  logic host_cs_n = 1'b1, host_read_strobe_n = 1'b1, host_write_strobe_n = 1'b1, hoe, serr;
  logic [11:0] ext_addr_low;
  logic [15:0] host_data_in = 16'h0, host_data_port, hq;
  logic [1:0] gp_inputs = 2'h0, gp_outputs;
  int error_cnt = 0, checked = 0, cyc = 0, n = 0;

  pport_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mode_slave, .ext_addr_low, .area_select_bit, .ext_rd_n, .ext_wr_n, .ext_data_in, .ext_data_out,
    .ext_data_oe, .host_cs_n, .host_read_strobe_n, .host_write_strobe_n, .host_data_in, .host_data_port,
    .host_data_oe, .host_transfer_request, .gp_inputs, .gp_outputs);
  ext_mem_model mem_m (.pclk, .ext_addr_low, .area_select_bit, .ext_rd_n, .ext_wr_n, .ext_data_out,
    .ext_data_oe, .ext_data_in);

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Hang guard, far above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Mode only changes under reset, since the port must not see it move while running
  task automatic rst(input logic m);
    presetn <= 1'b0;
    mode_slave <= m;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // One APB transfer; an idle edge follows so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll status until the data access engine is free
  task automatic idle;
    n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 50);
    cmp(q[STAT_BUSY], 1'b0);
  endtask
  // Count falling edges until a memory strobe is seen low, giving up after 64;
  // pins are taken mid-cycle where they are settled, then a rising edge passes
  task automatic strobe(input logic wr);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((wr ? ext_wr_n : ext_rd_n) !== 1'b0 && n < 64);
    pins = {ext_data_oe, area_select_bit, ext_addr_low};
    dout = ext_data_out;
    @(posedge pclk);
  endtask
  // One host strobe of two cycles, select asserted with it and held two cycles after it
  task automatic host(input logic cs_n, input logic rd, input logic [15:0] d);
    host_cs_n <= cs_n;
    host_read_strobe_n <= !rd;
    host_write_strobe_n <= rd;
    host_data_in <= d;
    repeat (2) @(posedge pclk);
    hq = host_data_port;
    hoe = host_data_oe;
    host_read_strobe_n <= 1'b1;
    host_write_strobe_n <= 1'b1;
    repeat (2) @(posedge pclk);
    host_cs_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_regs;
    rst(1'b0);
    cmp(ext_data_oe, 1'b0);
    apb(1'b0, CTRL_OFF, 32'h0);
    cmp(q, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
    cmp(q, 32'h0);
    apb(1'b1, RDATA_OFF, 32'hffffffff);
    apb(1'b0, RDATA_OFF, 32'h0);
    cmp(q, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    cmp({serr, q}, {1'b1, 32'h0});
  endtask
  // Write then read one word in the fast or the slow half, timing the strobe
  task automatic t_data(input logic ar);
    logic [12:0] a;
    logic [31:0] d;
    a = {ar, 12'h0a5};
    d = {19'h5a5a0, a};
    apb(1'b1, EXT_ADDR_OFF, {19'h0, a});
    apb(1'b1, WDATA_OFF, d);
    apb(1'b1, CTRL_OFF, 32'h6);
    strobe(1'b1);
    cmp(32'(ar ? (n >= 15 && n <= 20) : (n >= 7 && n <= 12)), 32'h1);
    cmp(pins, {1'b1, a});
    cmp(dout, d);
    idle();
    cmp(mem_m.mem[a], d);
    mem_m.mem[a] = ~d;
    apb(1'b1, CTRL_OFF, 32'h2);
    strobe(1'b0);
    cmp(pins, {1'b0, a});
    idle();
    apb(1'b0, RDATA_OFF, 32'h0);
    cmp(q, ~d);
  endtask
  // Fetches from the external area, one instruction every four pclk
  task automatic t_fetch;
    logic [12:0] a;
    for (int i = 0; i < 16; i++) mem_m.mem[13'h1003 + i] = 32'hc0de0000 + i;
    apb(1'b1, IPTR_OFF, 32'h1003);
    apb(1'b1, CTRL_OFF, 32'h1);
    strobe(1'b0);
    a = pins[12:0];
    cmp(32'(a >= 13'h1003 && a <= 13'h1004), 32'h1);
    strobe(1'b0);
    cmp(n, 4);
    cmp(pins[12:0], a + 13'h1);
    apb(1'b1, CTRL_OFF, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, INSTR_OFF, 32'h0);
    cmp(q, mem_m.mem[mem_m.last_rd]);
  endtask
  // Byte assembly over the narrow bus; the one-byte read shifts the older bytes down
  task automatic t_slave;
    rst(1'b1);
    for (int i = 0; i < 4; i++) mem_m.mem[13'h0010 + i] = 32'hffffff11 * (i + 1);
    mem_m.mem[13'h1020] = 32'hffffff55;
    apb(1'b1, EXT_ADDR_OFF, 32'h10);
    apb(1'b1, CTRL_OFF, 32'h1a);
    idle();
    apb(1'b0, RDATA_OFF, 32'h0);
    cmp(q, 32'h44332211);
    apb(1'b1, EXT_ADDR_OFF, 32'h1020);
    apb(1'b1, CTRL_OFF, 32'h2);
    idle();
    apb(1'b0, RDATA_OFF, 32'h0);
    cmp(q, 32'h55443322);
    apb(1'b1, WDATA_OFF, 32'h3c5a);
    apb(1'b1, EXT_ADDR_OFF, 32'h30);
    apb(1'b1, CTRL_OFF, 32'he);
    idle();
    cmp({mem_m.mem[13'h31][7:0], mem_m.mem[13'h30][7:0]}, 32'h3c5a);
    apb(1'b1, IPTR_OFF, 32'h1000);
    apb(1'b1, CTRL_OFF, 32'h1);
    strobe(1'b0);
    cmp(n, 64);
    apb(1'b1, CTRL_OFF, 32'h0);
  endtask
  // Host reads and writes, ignored strobes without select, narrow and wide requests
  task automatic t_host;
    apb(1'b1, HOSTDATA_OFF, 32'h1234abcd);
    host(1'b0, 1'b1, 16'h0);
    cmp({hoe, hq}, {1'b1, 16'habcd});
    host(1'b1, 1'b1, 16'h0);
    cmp(hoe, 1'b0);
    host(1'b1, 1'b0, 16'hffff);
    apb(1'b0, HOSTDATA_OFF, 32'h0);
    cmp(q, 32'h1234abcd);
    apb(1'b1, CTRL_OFF, 32'h140);
    cmp(host_transfer_request, 1'b1);
    host(1'b0, 1'b0, 16'h5a5a);
    cmp(host_transfer_request, 1'b0);
    apb(1'b0, HOSTDATA_OFF, 32'h0);
    cmp(q, 32'h12345a5a);
    apb(1'b1, CTRL_OFF, 32'h160);
    host(1'b0, 1'b0, 16'h1111);
    cmp(host_transfer_request, 1'b1);
    host(1'b0, 1'b0, 16'h2222);
    cmp(host_transfer_request, 1'b0);
    apb(1'b0, HOSTDATA_OFF, 32'h0);
    cmp(q, 32'h22221111);
    gp_inputs <= 2'h1;
    repeat (8) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0);
    cmp(q[4:2], 3'h5);
    cmp(gp_outputs, 2'h2);
  endtask

  // Main sequence: master scenarios first, then slave mode after a fresh reset
  initial begin
    t_regs();
    t_data(1'b0);
    t_data(1'b1);
    t_fetch();
    t_slave();
    t_host();
    conclude();
  end
endmodule
`default_nettype wire
